// ---- bax_cfg.svh ----
// Constants for the byte ALU slice: widths, destination codes, field positions and reset values.
// What this block does
// RL1: Subtract working register from file register, flags.
// RL2: Destination bit picks working or file register.
// RL3: Nibble swap exchanges halves, flags unchanged.
// RL4: XOR with file updates zero only.
// RL5: XOR with literal always writes working register.
// RL6: Zero on zero result; carry means no borrow.
`ifndef BAX_CFG_SVH
`define BAX_CFG_SVH
`define BAX_DATA_W 8
`define BAX_ADDR_W 7
`define BAX_ADDR_MAX 7'h7f
`define BAX_NIB_LO_MSB 3
`define BAX_NIB_HI_LSB 4
`define BAX_DEST_ACC 1'h0
`define BAX_DEST_FILE 1'h1
`define BAX_ACC_RST 8'h00
`define BAX_FLAG_RST 1'h0
`endif

// ---- bax_pkg.sv ----
// Types shared by the byte ALU slice.
package bax_pkg;
	typedef enum logic [3:0]
	{
		BAX_OP_SUB = 4'h1,
		BAX_OP_SWAP = 4'h2,
		BAX_OP_XORF = 4'h4,
		BAX_OP_XORL = 4'h8
	} bax_op_t;

	typedef struct packed
	{
		logic zero;
		logic digit_carry_flag;
		logic carry;
	} bax_flags_t;

	typedef struct packed
	{
		logic valid;
		bax_op_t op;
		logic dest;
		logic [6:0] addr;
		logic [7:0] file_data;
		logic [7:0] literal;
	} bax_req_t;

	typedef struct packed
	{
		logic we;
		logic [6:0] addr;
		logic [7:0] data;
	} bax_wb_t;
endpackage

// ---- bax_alu.sv ----
// Byte ALU slice: subtract, nibble swap and XOR with working register and status flags.
`timescale 1ns/10ps
`include "bax_cfg.svh"
module bax_alu
	import bax_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire bax_req_t i_req,
	output bax_wb_t o_file_wb,
	output logic [7:0] o_acc,
	output bax_flags_t o_flags
);

	////////////////////////////////////////////////////////////////////////////
	logic [7:0] acc_q;
	bax_flags_t flags_q;
	bax_wb_t wb_q;
	logic [7:0] res;
	logic [8:0] diff;
	logic [4:0] ndiff;
	logic to_acc;

	// Arithmetic: file minus working register via two's complement add.
	assign diff = {1'b0, i_req.file_data} + {1'b0, ~acc_q} + 9'h001; // [RL1]
	assign ndiff = {1'b0, i_req.file_data[3:0]} + {1'b0, ~acc_q[3:0]} + 5'h01; // [RL1]

	// Result selection per operation.
	always_comb
	begin
		res = i_req.file_data;
		unique case (i_req.op)
			BAX_OP_SUB: res = diff[7:0]; // [RL1]
			BAX_OP_SWAP: res = {i_req.file_data[`BAX_NIB_LO_MSB:0],
				i_req.file_data[`BAX_DATA_W-1:`BAX_NIB_HI_LSB]}; // [RL3]
			BAX_OP_XORF: res = acc_q ^ i_req.file_data; // [RL4]
			BAX_OP_XORL: res = acc_q ^ i_req.literal; // [RL5]
			default: res = i_req.file_data;
		endcase
	end

	// Literal form always targets the working register; file forms obey dest.
	assign to_acc = (i_req.op == BAX_OP_XORL) || (i_req.dest == `BAX_DEST_ACC); // [RL2] [RL5]

	////////////////////////////////////////////////////////////////////////////
	// Working register update.
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
			acc_q <= `BAX_ACC_RST;
		else if (i_req.valid && to_acc)
			acc_q <= res; // [RL2]
	end

	// File write-back port, one cycle pulse per file-directed result.
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
			wb_q <= '0;
		else
		begin
			wb_q.we <= i_req.valid && !to_acc; // [RL2]
			wb_q.addr <= i_req.addr;
			wb_q.data <= res;
		end
	end

	// Status flags per operation.
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
			flags_q <= '{`BAX_FLAG_RST, `BAX_FLAG_RST, `BAX_FLAG_RST};
		else if (i_req.valid)
		begin
			if (i_req.op == BAX_OP_SUB)
			begin
				flags_q.carry <= diff[8]; // [RL6] Set means no borrow.
				flags_q.digit_carry_flag <= ndiff[4]; // [RL1]
			end
			if (i_req.op != BAX_OP_SWAP)
				flags_q.zero <= (res == 8'h00); // [RL6] [RL3]
		end
	end

	assign o_acc = acc_q;
	assign o_flags = flags_q;
	assign o_file_wb = wb_q;

	////////////////////////////////////////////////////////////////////////////
	property p_swap_keeps_flags;
		@(posedge i_mclk) disable iff (!i_rstn)
		(i_req.valid && i_req.op == BAX_OP_SWAP) |=> o_flags == $past(o_flags);
	endproperty
	a_swap_keeps_flags: assert property (p_swap_keeps_flags) // [RL3]
		else $error("swap changed flags");

	property p_xor_keeps_carry;
		@(posedge i_mclk) disable iff (!i_rstn)
		(i_req.valid && i_req.op[3:2] != 2'b00) |=> (o_flags.carry == $past(o_flags.carry)
			&& o_flags.digit_carry_flag == $past(o_flags.digit_carry_flag));
	endproperty
	a_xor_keeps_carry: assert property (p_xor_keeps_carry) // [RL4]
		else $error("xor changed carry");

	property p_xorl_to_acc;
		@(posedge i_mclk) disable iff (!i_rstn)
		(i_req.valid && i_req.op == BAX_OP_XORL) |=>
			(o_acc == ($past(o_acc) ^ $past(i_req.literal)) && !o_file_wb.we);
	endproperty
	a_xorl_to_acc: assert property (p_xorl_to_acc) // [RL5]
		else $error("literal xor misrouted");

	property p_sub_value;
		@(posedge i_mclk) disable iff (!i_rstn)
		(i_req.valid && i_req.op == BAX_OP_SUB && i_req.dest) |=>
			(o_file_wb.we && o_file_wb.data == 8'($past(i_req.file_data) - $past(o_acc)));
	endproperty
	a_sub_value: assert property (p_sub_value) // [RL1]
		else $error("subtract value wrong");

	property p_sub_carry;
		@(posedge i_mclk) disable iff (!i_rstn)
		(i_req.valid && i_req.op == BAX_OP_SUB) |=>
			o_flags.carry == ($past(i_req.file_data) >= $past(o_acc));
	endproperty
	a_sub_carry: assert property (p_sub_carry) // [RL6]
		else $error("borrow sense wrong");

	property p_zero_flag;
		@(posedge i_mclk) disable iff (!i_rstn)
		(i_req.valid && i_req.op != BAX_OP_SWAP && !i_req.dest) |=>
			o_flags.zero == (o_acc == 8'h00);
	endproperty
	a_zero_flag: assert property (p_zero_flag) // [RL6]
		else $error("zero flag wrong");

	property p_dest_acc_keeps_file;
		@(posedge i_mclk) disable iff (!i_rstn)
		(i_req.valid && !i_req.dest) |=> !o_file_wb.we;
	endproperty
	a_dest_acc_keeps_file: assert property (p_dest_acc_keeps_file) // [RL2]
		else $error("file written");

	property p_dest_file_keeps_acc;
		@(posedge i_mclk) disable iff (!i_rstn)
		(i_req.valid && i_req.dest && i_req.op != BAX_OP_XORL) |=> o_acc == $past(o_acc);
	endproperty
	a_dest_file_keeps_acc: assert property (p_dest_file_keeps_acc) // [RL2]
		else $error("acc written");

	property p_swap_value;
		@(posedge i_mclk) disable iff (!i_rstn)
		(i_req.valid && i_req.op == BAX_OP_SWAP && !i_req.dest) |=>
			o_acc == {$past(i_req.file_data[3:0]), $past(i_req.file_data[7:4])};
	endproperty
	a_swap_value: assert property (p_swap_value) // [RL3]
		else $error("swap value wrong");

	// Subtract sends its difference to the working register when asked.
	property p_sub_to_acc;
		@(posedge i_mclk) disable iff (!i_rstn)
		(i_req.valid && i_req.op == BAX_OP_SUB && !i_req.dest) |=>
			o_acc == 8'($past(i_req.file_data) - $past(o_acc));
	endproperty
	a_sub_to_acc: assert property (p_sub_to_acc) // [RL1]
		else $error("subtract to working register wrong");

	// Digit carry is set when the low nibble needs no borrow.
	property p_sub_digit_carry;
		@(posedge i_mclk) disable iff (!i_rstn)
		(i_req.valid && i_req.op == BAX_OP_SUB) |=>
			o_flags.digit_carry_flag == ($past(i_req.file_data[3:0]) >= $past(o_acc[3:0]));
	endproperty
	a_sub_digit_carry: assert property (p_sub_digit_carry) // [RL1]
		else $error("digit carry wrong");

	// Exclusive OR with a file register, result sent back to the file.
	property p_xorf_to_file;
		@(posedge i_mclk) disable iff (!i_rstn)
		(i_req.valid && i_req.op == BAX_OP_XORF && i_req.dest) |=>
			(o_file_wb.we && o_file_wb.data == ($past(o_acc) ^ $past(i_req.file_data)));
	endproperty
	a_xorf_to_file: assert property (p_xorf_to_file) // [RL4]
		else $error("file xor to file wrong");

	// Exclusive OR with a file register, result kept in the working register.
	property p_xorf_to_acc;
		@(posedge i_mclk) disable iff (!i_rstn)
		(i_req.valid && i_req.op == BAX_OP_XORF && !i_req.dest) |=>
			o_acc == ($past(o_acc) ^ $past(i_req.file_data));
	endproperty
	a_xorf_to_acc: assert property (p_xorf_to_acc) // [RL4]
		else $error("file xor to working register wrong");

	// Nibble swap written back to the file register.
	property p_swap_to_file;
		@(posedge i_mclk) disable iff (!i_rstn)
		(i_req.valid && i_req.op == BAX_OP_SWAP && i_req.dest) |=>
			(o_file_wb.we && o_file_wb.data == {$past(i_req.file_data[3:0]),
			$past(i_req.file_data[7:4])});
	endproperty
	a_swap_to_file: assert property (p_swap_to_file) // [RL3]
		else $error("swap to file wrong");

	// The zero flag follows a file-directed result as well.
	property p_file_zero;
		@(posedge i_mclk) disable iff (!i_rstn)
		(i_req.valid && i_req.dest
			&& (i_req.op == BAX_OP_SUB || i_req.op == BAX_OP_XORF)) |=>
			o_flags.zero == (o_file_wb.data == 8'h00);
	endproperty
	a_file_zero: assert property (p_file_zero) // [RL6]
		else $error("zero flag wrong for file result");

	// File-directed results carry the address of their request.
	property p_file_addr;
		@(posedge i_mclk) disable iff (!i_rstn)
		(i_req.valid && i_req.dest && i_req.op != BAX_OP_XORL) |=>
			(o_file_wb.we && o_file_wb.addr == $past(i_req.addr));
	endproperty
	a_file_addr: assert property (p_file_addr) // [RL2]
		else $error("file write address wrong");

	// No request means no file write in the next cycle.
	property p_idle_no_write;
		@(posedge i_mclk) disable iff (!i_rstn)
		!i_req.valid |=> !o_file_wb.we;
	endproperty
	a_idle_no_write: assert property (p_idle_no_write) // [RL2]
		else $error("file write without request");

	// Reset leaves the working register, flags and write strobe at rest.
	property p_reset_values;
		@(posedge i_mclk)
		!i_rstn |=> (o_acc == `BAX_ACC_RST && !o_file_wb.we
			&& o_flags == {`BAX_FLAG_RST, `BAX_FLAG_RST, `BAX_FLAG_RST});
	endproperty
	a_reset_values: assert property (p_reset_values) // [RL6]
		else $error("reset values wrong");
endmodule

// ---- bax_tb.sv ----
// Self-checking testbench for the byte ALU slice.
`timescale 1ns/10ps
module testbench
	import bax_pkg::*;
;
	logic i_mclk = 1'b0;
	logic i_rstn = 1'b0;
	bax_req_t i_req = '0;
	bax_wb_t o_file_wb;
	logic [7:0] o_acc;
	bax_flags_t o_flags;
	int mismatches = 0;
	int compares = 0;
	int cycles = 0;

	bax_alu u_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_req(i_req),
		.o_file_wb(o_file_wb), .o_acc(o_acc), .o_flags(o_flags));

	// Clock of 20 ns period.
	always #10 i_mclk = ~i_mclk;

	////////////////////////////////////////////////////////////////
	// Compares a byte result.
	task automatic ck(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// Compares the flags as {zero, digit carry, carry}.
	task automatic ckf(input bax_flags_t g, input logic [2:0] e);
		ck({5'h00, g}, {5'h00, e});
	endtask

	// Presents one request for one cycle, returns once its result has landed.
	task automatic issue(input bax_op_t op, input logic d, input logic [6:0] a,
		input logic [7:0] fd, input logic [7:0] lit);
		@(posedge i_mclk) #1;
		i_req = '{1'b1, op, d, a, fd, lit};
		@(posedge i_mclk) #1;
		i_req.valid = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////
	// Subtraction with and without borrow, both destinations.
	task automatic t_sub;
		issue(BAX_OP_XORL, 1'b1, 7'h7f, 8'h00, 8'h01);
		ck(o_acc, 8'h01);
		ck({7'h00, o_file_wb.we}, 8'h00);
		issue(BAX_OP_SUB, 1'b1, 7'h7f, 8'h10, 8'h00);
		ck(o_file_wb.data, 8'h0f);
		ck({o_file_wb.we, o_file_wb.addr}, 8'hff);
		ck(o_acc, 8'h01);
		ckf(o_flags, 3'b001);
		issue(BAX_OP_SUB, 1'b0, 7'h00, 8'h00, 8'h00);
		ck(o_acc, 8'hff);
		ckf(o_flags, 3'b000);
		issue(BAX_OP_SUB, 1'b0, 7'h00, 8'hff, 8'h00);
		ck(o_acc, 8'h00);
		ckf(o_flags, 3'b111);
		$display("test sub done");
	endtask

	// Nibble swap and both exclusive OR forms keep carry and digit carry.
	task automatic t_swap_xor;
		issue(BAX_OP_SWAP, 1'b0, 7'h00, 8'ha5, 8'h00);
		ck(o_acc, 8'h5a);
		ckf(o_flags, 3'b111);
		issue(BAX_OP_SWAP, 1'b1, 7'h2a, 8'h3c, 8'h00);
		ck(o_file_wb.data, 8'hc3);
		ck({o_file_wb.we, o_file_wb.addr}, 8'haa);
		issue(BAX_OP_XORF, 1'b1, 7'h11, 8'h5a, 8'h00);
		ck(o_file_wb.data, 8'h00);
		ckf(o_flags, 3'b111);
		issue(BAX_OP_XORF, 1'b0, 7'h11, 8'hff, 8'h00);
		ck(o_acc, 8'ha5);
		ckf(o_flags, 3'b011);
		issue(BAX_OP_XORL, 1'b1, 7'h11, 8'h00, 8'ha5);
		ck(o_acc, 8'h00);
		ckf(o_flags, 3'b111);
		$display("test swap and xor done");
	endtask

	// A reset in mid-run puts working register, flags and write port back at rest.
	task automatic t_reset;
		issue(BAX_OP_XORL, 1'b0, 7'h00, 8'h00, 8'h5a);
		ck(o_acc, 8'h5a);
		issue(BAX_OP_SUB, 1'b1, 7'h05, 8'hff, 8'h00);
		ck(o_file_wb.data, 8'ha5);
		ckf(o_flags, 3'b011);
		@(posedge i_mclk) #1;
		ck({7'h00, o_file_wb.we}, 8'h00);
		i_rstn = 1'b0;
		@(posedge i_mclk) #1;
		i_rstn = 1'b1;
		ck(o_acc, 8'h00);
		ckf(o_flags, 3'b000);
		ck({o_file_wb.we, o_file_wb.addr}, 8'h00);
		ck(o_file_wb.data, 8'h00);
		$display("test reset done");
	endtask

	////////////////////////////////////////////////////////////////
	// Prints the counts and the verdict, then ends the run.
	task automatic results;
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Cuts a hang short.
	always @(posedge i_mclk)
	begin
		cycles++;
		if (cycles == 1000)
		begin
			mismatches++;
			results();
		end
	end

	// Main sequence.
	initial
	begin
		repeat (8) @(posedge i_mclk);
		#1 i_rstn = 1'b1;
		t_sub();
		t_swap_xor();
		t_reset();
		results();
	end
endmodule
